// ### inc/slsr_pkg.sv
// Function
// (RULE_01) Lane 0 CR, EQ, lock in bits 0-2
// (RULE_02) Lane 1 CR, EQ, lock in bits 4-6
// (RULE_03) Status bits 3 and 7 read zero
// (RULE_04) Lanes 2-3 status byte, same layout
// (RULE_05) Alignment done bit 0, bits 5:1 zero
// (RULE_06) Bit 6 set on downstream port change
// (RULE_07) Bit 7 set on change, cleared by read
// (RULE_08) Sink status bit 0: port 0 sync
// (RULE_09) Bit 1 port 1 sync, bits 7:2 zero
// (RULE_10) Lane 0 swing request in bits 1:0
// (RULE_11) Lane 0 emphasis request in bits 3:2
// (RULE_12) Lane 1 swing request in bits 5:4
// (RULE_13) Two-bit levels encode 0 through 3
// (RULE_14) Four training score bytes read zero
// (RULE_15) Vector bit 6 vendor flag, others zero
// (RULE_16) Lane 1 emphasis request in bits 7:6
// (RULE_17) Lanes 2-3 adjust byte, same layout
// (RULE_18) Source writes to these bytes ignored
// (RULE_19) Reset clears all flags and levels
package slsr_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [19:0] SLSR_ADDR_VECTOR = 20'h00201;
  localparam logic [19:0] SLSR_ADDR_LANES01 = 20'h00202;
  localparam logic [19:0] SLSR_ADDR_LANES23 = 20'h00203;
  localparam logic [19:0] SLSR_ADDR_ALIGN = 20'h00204;
  localparam logic [19:0] SLSR_ADDR_SYNC = 20'h00205;
  localparam logic [19:0] SLSR_ADDR_ADJ01 = 20'h00206;
  localparam logic [19:0] SLSR_ADDR_ADJ23 = 20'h00207;
  localparam logic [19:0] SLSR_ADDR_SCORE0 = 20'h00208;
  localparam logic [19:0] SLSR_ADDR_SCORE3 = 20'h0020B;
  // ==========================================================
  // Field positions
  localparam int SLSR_LANE_HI_POS = 4;
  localparam int SLSR_ALIGN_POS = 0;
  localparam int SLSR_DS_CHG_POS = 6;
  localparam int SLSR_UPD_POS = 7;
  localparam int SLSR_VENDOR_POS = 6;
  localparam logic [7:0] SLSR_RESET_VAL = 8'h00;
endpackage

// ### rtl/slsr_regs.sv
`timescale 1ns/1ns
module slsr_regs
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Training state from link logic, per lane and link-wide
  input wire logic [3:0] lane_clk_recovered_i,
  input wire logic [3:0] lane_equalized_i,
  input wire logic [3:0] lane_sym_lock_i,
  input wire logic cross_lane_aligned_i,
  input wire logic downstream_change_i,
  input wire logic [1:0] port_sync_i,
  input wire logic vendor_irq_i,
  // Requested levels, two bits per lane
  input wire logic [7:0] lane_swing_req_i,
  input wire logic [7:0] lane_emph_req_i,
  // Sideband channel register access
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o
);
  // ==========================================================
  // Captured status
  logic [7:0] lanes01_status_reg;
  logic [7:0] lanes23_status_reg;
  logic [7:0] lanes01_adjust_reg;
  logic [7:0] lanes23_adjust_reg;
  logic aligned_reg;
  logic [1:0] sync_reg;
  logic vendor_reg;
  logic ds_chg_reg;
  logic updated_reg;
  logic [7:0] lanes01_status_next;
  logic [7:0] lanes23_status_next;
  logic [7:0] lanes01_adjust_next;
  logic [7:0] lanes23_adjust_next;
  logic [7:0] align_byte;
  logic changed;
  logic rd_align;

  // Nibble per lane: bits 2:0 status, bit 3 zero
  always_comb
  begin
    lanes01_status_next = {1'b0, lane_sym_lock_i[1], lane_equalized_i[1],
      lane_clk_recovered_i[1], 1'b0, lane_sym_lock_i[0],
      lane_equalized_i[0], lane_clk_recovered_i[0]}; // RULE_01 RULE_02 RULE_03
    lanes23_status_next = {1'b0, lane_sym_lock_i[3], lane_equalized_i[3],
      lane_clk_recovered_i[3], 1'b0, lane_sym_lock_i[2],
      lane_equalized_i[2], lane_clk_recovered_i[2]}; // RULE_04 RULE_03
    // Byte: emph1, swing1, emph0, swing0
    lanes01_adjust_next = {lane_emph_req_i[3:2], lane_swing_req_i[3:2],
      lane_emph_req_i[1:0], lane_swing_req_i[1:0]}; // RULE_10 RULE_11 RULE_12 RULE_16 RULE_13
    lanes23_adjust_next = {lane_emph_req_i[7:6], lane_swing_req_i[7:6],
      lane_emph_req_i[5:4], lane_swing_req_i[5:4]}; // RULE_17
  end

  assign changed = (lanes01_status_next != lanes01_status_reg)
    || (lanes23_status_next != lanes23_status_reg)
    || (lanes01_adjust_next != lanes01_adjust_reg)
    || (lanes23_adjust_next != lanes23_adjust_reg);
  assign rd_align = rd_i && (addr_i == slsr_pkg::SLSR_ADDR_ALIGN);

  // Only link inputs load these; wr_i never reaches them
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      lanes01_status_reg <= slsr_pkg::SLSR_RESET_VAL; // RULE_19
      lanes23_status_reg <= slsr_pkg::SLSR_RESET_VAL;
      lanes01_adjust_reg <= slsr_pkg::SLSR_RESET_VAL;
      lanes23_adjust_reg <= slsr_pkg::SLSR_RESET_VAL;
      aligned_reg <= 1'b0;
      sync_reg <= 2'h0;
      vendor_reg <= 1'b0;
    end
    else
    begin
      lanes01_status_reg <= lanes01_status_next; // RULE_18
      lanes23_status_reg <= lanes23_status_next;
      lanes01_adjust_reg <= lanes01_adjust_next;
      lanes23_adjust_reg <= lanes23_adjust_next;
      aligned_reg <= cross_lane_aligned_i;
      sync_reg <= port_sync_i; // RULE_08 RULE_09
      vendor_reg <= vendor_irq_i;
    end
  end

  // Sticky update flag; a change in the read cycle wins
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      updated_reg <= 1'b0;
    else if (changed)
      updated_reg <= 1'b1; // RULE_07
    else if (rd_align)
      updated_reg <= 1'b0; // RULE_07
  end

  // Downstream change held until the source reads it
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      ds_chg_reg <= 1'b0;
    else if (downstream_change_i)
      ds_chg_reg <= 1'b1; // RULE_06
    else if (rd_align)
      ds_chg_reg <= 1'b0;
  end

  always_comb
  begin
    align_byte = 8'h00; // RULE_05
    align_byte[slsr_pkg::SLSR_ALIGN_POS] = aligned_reg; // RULE_05
    align_byte[slsr_pkg::SLSR_DS_CHG_POS] = ds_chg_reg;
    align_byte[slsr_pkg::SLSR_UPD_POS] = updated_reg;
  end

  // ==========================================================
  // Read port, one cycle latency; unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= rd_i;
      rdata_o <= 8'h00; // RULE_14
      if (rd_i)
      begin
        unique case (addr_i)
          slsr_pkg::SLSR_ADDR_VECTOR:
            rdata_o <= {1'b0, vendor_reg, 6'h00}; // RULE_15
          slsr_pkg::SLSR_ADDR_LANES01: rdata_o <= lanes01_status_reg;
          slsr_pkg::SLSR_ADDR_LANES23: rdata_o <= lanes23_status_reg;
          slsr_pkg::SLSR_ADDR_ALIGN: rdata_o <= align_byte;
          slsr_pkg::SLSR_ADDR_SYNC: rdata_o <= {6'h00, sync_reg}; // RULE_09
          slsr_pkg::SLSR_ADDR_ADJ01: rdata_o <= lanes01_adjust_reg;
          slsr_pkg::SLSR_ADDR_ADJ23: rdata_o <= lanes23_adjust_reg;
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  property p_upd_set;
    @(posedge clk_i) disable iff (!reset_n_i)
      changed |=> updated_reg;
  endproperty
  a_upd_set: assert property (p_upd_set) else $error("update flag missed"); // RULE_07

  property p_upd_clr;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_align && !changed) |=> !updated_reg;
  endproperty
  a_upd_clr: assert property (p_upd_clr) else $error("update not cleared"); // RULE_07

  property p_ds;
    @(posedge clk_i) disable iff (!reset_n_i)
      downstream_change_i |=> ds_chg_reg;
  endproperty
  a_ds: assert property (p_ds) else $error("downstream flag missed"); // RULE_06

  // Flag survives until a read of the alignment byte
  property p_ds_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ds_chg_reg && !rd_align) |=> ds_chg_reg;
  endproperty
  a_ds_hold: assert property (p_ds_hold) else $error("downstream flag lost"); // RULE_06

  // A read answers on the next edge and stands for one cycle
  sequence s_read_taken;
    rd_i;
  endsequence

  sequence s_read_answer;
    rvalid_o;
  endsequence

  property p_answer;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_read_taken |=> s_read_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered"); // RULE_18

  property p_idle;
    @(posedge clk_i) disable iff (!reset_n_i)
      !rd_i |=> !rvalid_o && rdata_o == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("idle bus not quiet"); // RULE_03

  property p_align;
    @(posedge clk_i) disable iff (!reset_n_i)
      rd_align |=> rdata_o[5:1] == 5'h00
        && rdata_o[0] == $past(aligned_reg);
  endproperty
  a_align: assert property (p_align) else $error("align byte bad"); // RULE_05

  property p_stat01;
    @(posedge clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == slsr_pkg::SLSR_ADDR_LANES01 |=>
        rdata_o[2:0] == $past(lanes01_status_reg[2:0]) && !rdata_o[3]
        && !rdata_o[7];
  endproperty
  a_stat01: assert property (p_stat01) else $error("lane status bad"); // RULE_01

  property p_sync;
    @(posedge clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == slsr_pkg::SLSR_ADDR_SYNC |=>
        rdata_o == {6'h00, $past(sync_reg)};
  endproperty
  a_sync: assert property (p_sync) else $error("sync byte bad"); // RULE_08

  property p_score;
    @(posedge clk_i) disable iff (!reset_n_i)
      rd_i && addr_i >= slsr_pkg::SLSR_ADDR_SCORE0
        && addr_i <= slsr_pkg::SLSR_ADDR_SCORE3 |=> rdata_o == 8'h00;
  endproperty
  a_score: assert property (p_score) else $error("score not zero"); // RULE_14

  property p_adj;
    @(posedge clk_i) disable iff (!reset_n_i)
      ##1 rd_i && addr_i == slsr_pkg::SLSR_ADDR_ADJ01 |=>
        rdata_o[7:6] == $past(lane_emph_req_i[3:2], 2)
        && rdata_o[1:0] == $past(lane_swing_req_i[1:0], 2);
  endproperty
  a_adj: assert property (p_adj) else $error("adjust byte bad"); // RULE_16

  property p_vec;
    @(posedge clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == slsr_pkg::SLSR_ADDR_VECTOR |=>
        rdata_o[7] == 1'b0 && rdata_o[5:2] == 4'h0;
  endproperty
  a_vec: assert property (p_vec) else $error("vector reserved set"); // RULE_15

  property p_wr;
    @(posedge clk_i) disable iff (!reset_n_i)
      wr_i && !changed |=> $stable(lanes01_adjust_reg);
  endproperty
  a_wr: assert property (p_wr) else $error("write altered reg"); // RULE_18
endmodule // slsr_regs

// ### sim/slsr_source_model.sv
`timescale 1ns/1ns
// ==========
// Upstream source on the sideband channel
module slsr_source_model
(
  // Clock
  input wire logic clk_i,
  // Requests
  output logic rd_o,
  output logic wr_o,
  output logic [19:0] addr_o,
  output logic [7:0] wdata_o,
  // Answers
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  initial
  begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 20'h00000;
    wdata_o = 8'h00;
  end
  // Strobe lasts one cycle; answer awaited a bounded number of edges
  task automatic read(input logic [19:0] a, output logic [7:0] d,
                      output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    for (int n = 0; n < 4 && !ok; n++)
    begin
      #1;
      if (rvalid_i === 1'b1)
      begin
        d = rdata_i;
        ok = 1'b1;
      end
      else
        @(posedge clk_i);
    end
  endtask
  // Idle data shows the inverse, never a stale copy
  task automatic write(input logic [19:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= v;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~v;
  endtask
endmodule // slsr_source_model

// ### sim/sink_link_status_regs_bench.sv
`timescale 1ns/1ns
module sink_link_status_regs_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] cr = 4'h0, eq = 4'h0, lk = 4'h0;
  logic aligned = 1'b0, ds_chg = 1'b0, vendor = 1'b0;
  logic [1:0] sync = 2'h0;
  logic [7:0] swing = 8'h00, emph = 8'h00, wdata, rdata;
  logic rd, wr, rvalid;
  logic [19:0] addr;
  int failures = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  slsr_regs DUT(.clk_i(clk), .reset_n_i(reset_n),
    .lane_clk_recovered_i(cr), .lane_equalized_i(eq),
    .lane_sym_lock_i(lk), .cross_lane_aligned_i(aligned),
    .downstream_change_i(ds_chg), .port_sync_i(sync),
    .vendor_irq_i(vendor), .lane_swing_req_i(swing),
    .lane_emph_req_i(emph), .rd_i(rd), .wr_i(wr), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid));
  slsr_source_model SRC(.clk_i(clk), .rd_o(rd), .wr_o(wr),
    .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
  // ==========
  // Reporting and checking
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    SRC.read(a, d, ok);
    if (!ok)
    begin
      failures++;
      wrap_up();
    end
    else
      chk(d, exp);
  endtask
  function automatic logic [7:0] pair(input int h);
    return {1'b0, lk[h+1], eq[h+1], cr[h+1], 1'b0, lk[h], eq[h], cr[h]};
  endfunction
  // ==========
  // Scenarios
  task automatic t_status();
    logic [11:0] pat [3] = '{12'hFFF, 12'h5A3, 12'h0C6};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      {cr, eq, lk} <= pat[i];
      repeat (2) @(posedge clk);
      rd_chk(slsr_pkg::SLSR_ADDR_LANES01, pair(0));
      rd_chk(slsr_pkg::SLSR_ADDR_LANES23, pair(2));
    end
    $display("status test done");
  endtask
  task automatic t_adjust();
    logic [1:0] v;
    for (int i = 0; i < 4; i++)
    begin
      v = 2'(i);
      @(posedge clk);
      swing <= {v, v + 2'h1, v + 2'h2, v + 2'h3};
      emph <= {v + 2'h3, v + 2'h2, v + 2'h1, v};
      repeat (2) @(posedge clk);
      rd_chk(slsr_pkg::SLSR_ADDR_ADJ01, {emph[3:2], swing[3:2], emph[1:0],
        swing[1:0]});
      rd_chk(slsr_pkg::SLSR_ADDR_ADJ23, {emph[7:6], swing[7:6], emph[5:4],
        swing[5:4]});
    end
    $display("adjust test done");
  endtask
  task automatic t_flags();
    logic [7:0] d;
    bit ok;
    // Earlier traffic leaves the update flag set
    SRC.read(slsr_pkg::SLSR_ADDR_ALIGN, d, ok);
    @(posedge clk);
    aligned <= 1'b1;
    ds_chg <= 1'b1;
    lk <= ~lk;
    @(posedge clk);
    ds_chg <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(slsr_pkg::SLSR_ADDR_ALIGN, 8'hC1);
    rd_chk(slsr_pkg::SLSR_ADDR_ALIGN, 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk);
      sync <= 2'(s);
      vendor <= s[0];
      repeat (2) @(posedge clk);
      rd_chk(slsr_pkg::SLSR_ADDR_SYNC, {6'h00, sync});
      rd_chk(slsr_pkg::SLSR_ADDR_VECTOR, {1'b0, vendor, 6'h00});
    end
    SRC.write(slsr_pkg::SLSR_ADDR_LANES01, 8'hFF);
    rd_chk(slsr_pkg::SLSR_ADDR_LANES01, pair(0));
    rd_chk(20'h00300, 8'h00);
    $display("flags test done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 'h200; a <= 'h20B; a++)
      rd_chk(20'(a), 8'h00);
    $display("reset test done");
    t_status();
    t_adjust();
    t_flags();
    wrap_up();
  end
endmodule // sink_link_status_regs_bench
